// [rtl/sps_pin_mux.sv]
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "sps_consts.svh"

// Behaviour
// [RULE1] Program select is asserted throughout every external program-space access.
// [RULE2] Data select is asserted throughout every external data-space access.
// [RULE3] I/O select is asserted throughout every external I/O-space access.
// [RULE4] Output-disable low floats the program, data and I/O select pins.
// [RULE5] Host-port mode turns the program select pin into the first host strobe input.
// [RULE6] Host-port mode turns the data select pin into the second host strobe input.
// [RULE7] Host-port mode turns the I/O select pin into subsystem B pin three.
// [RULE8] In external-interface mode, I/O strobe and I/O select act only for I/O accesses.
// [RULE9] Host mode with mux setting 0: pin three follows its general-purpose register.
// [RULE10] Timer select set drives timer onto pin three; clear keeps general-purpose use.
// [RULE11] Pin two offers the same direction and data control as pins zero and one.
// [RULE12] Pin two as input feeds the branch-condition flag, else reads as plain input.
// [RULE13] Each general-purpose pin direction comes from its own direction field.
// [RULE14] At most one space select is asserted, matching the current access space.
module sps_pin_mux #(
  parameter int GP_PINS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sps_pkg::sps_access_s cpu_access,
  input wire logic off_n,
  input wire logic [1:0] timer_level,
  output logic program_space_select_n_out,
  output logic program_space_select_n_oe_n,
  input wire logic program_space_select_n_in,
  output logic data_space_select_n_out,
  output logic data_space_select_n_oe_n,
  input wire logic data_space_select_n_in,
  output logic io_space_select_n_out,
  output logic io_space_select_n_oe_n,
  input wire logic io_space_select_n_in,
  output logic io_strobe_n_out,
  output logic io_strobe_n_oe_n,
  input wire logic io_strobe_n_in,
  output logic host_data_strobe_first,
  output logic host_data_strobe_second,
  output logic [1:0][GP_PINS-2:0] gp_pin_out,
  output logic [1:0][GP_PINS-2:0] gp_pin_oe_n,
  input wire logic [1:0][GP_PINS-2:0] gp_pin_in,
  output logic [1:0] branch_condition_input
);

  // Register lanes are one byte wide and pin three must exist
  if (GP_PINS < 4 || GP_PINS > 8)
  begin : g_bad_pins
    $error("GP_PINS must lie between 4 and 8");
  end

  // Decoding shared by the read and write paths
  function automatic sps_pkg::sps_reg_e sps_decode(input logic [11:0] addr);
    unique case (addr)
      `SPS_REG_CTRL: sps_decode = sps_pkg::SPS_SEL_CTRL;
      `SPS_REG_GP_A: sps_decode = sps_pkg::SPS_SEL_GP_A;
      `SPS_REG_GP_B: sps_decode = sps_pkg::SPS_SEL_GP_B;
      `SPS_REG_STATUS: sps_decode = sps_pkg::SPS_SEL_STATUS;
      default: sps_decode = sps_pkg::SPS_SEL_NONE;
    endcase
  endfunction

  logic ext_if_sel;
  logic host_port_mux_mode;
  logic [1:0] timer_output_select;
  logic [1:0][GP_PINS-1:0] gp_data;
  logic [1:0][GP_PINS-1:0] pin_direction_field;
  logic [1:0][GP_PINS-1:0] pin_level;
  logic [31:0] next_prdata;
  sps_pkg::sps_reg_e reg_sel;
  logic apb_access;
  logic apb_write;
  logic space_prog;
  logic space_data;
  logic space_io;
  logic [1:0] next_gp3_out;
  logic [1:0] next_gp3_oe_n;

  assign reg_sel = sps_decode(paddr);
  // One wait state: the access phase first sees pready low, then high
  assign apb_access = psel && penable && !pready;
  // Writes land only on the edge where the master samples pready high
  assign apb_write = psel && penable && pready && pwrite;

  // APB handshake and registered read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_access;
      pslverr <= apb_access && reg_sel == sps_pkg::SPS_SEL_NONE;
      prdata <= (apb_access && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Read mux; unused bits read as zero
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (reg_sel)
      sps_pkg::SPS_SEL_CTRL:
      begin
        next_prdata[`SPS_CTRL_EXT_IF_BIT] = ext_if_sel;
        next_prdata[`SPS_CTRL_HOST_MUX_BIT] = host_port_mux_mode;
        next_prdata[`SPS_CTRL_TIMER_SEL_LSB +: 2] = timer_output_select;
      end
      sps_pkg::SPS_SEL_GP_A, sps_pkg::SPS_SEL_GP_B:
      begin
        next_prdata[`SPS_GP_OUT_LSB +: GP_PINS] = gp_data[reg_sel == sps_pkg::SPS_SEL_GP_B];
        next_prdata[`SPS_GP_DIR_LSB +: GP_PINS] =
          pin_direction_field[reg_sel == sps_pkg::SPS_SEL_GP_B];
        next_prdata[`SPS_GP_IN_LSB +: GP_PINS] = pin_level[reg_sel == sps_pkg::SPS_SEL_GP_B];
      end
      sps_pkg::SPS_SEL_STATUS:
      begin
        next_prdata[`SPS_STAT_BRANCH_LSB +: 2] = branch_condition_input;
        next_prdata[`SPS_STAT_SEL_LSB +: 3] =
          ~{io_space_select_n_out, data_space_select_n_out, program_space_select_n_out};
      end
      sps_pkg::SPS_SEL_NONE: next_prdata = 32'h0000_0000;
    endcase
  end

  // Mode control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_if_sel <= `SPS_EXT_IF_RESET;
      host_port_mux_mode <= `SPS_HOST_MUX_RESET;
      timer_output_select <= `SPS_TIMER_SEL_RESET;
    end
    else if (apb_write && reg_sel == sps_pkg::SPS_SEL_CTRL)
    begin
      ext_if_sel <= pwdata[`SPS_CTRL_EXT_IF_BIT];
      host_port_mux_mode <= pwdata[`SPS_CTRL_HOST_MUX_BIT];
      timer_output_select <= pwdata[`SPS_CTRL_TIMER_SEL_LSB +: 2];
    end
  end

  // Per-subsystem data and direction; all pins share one layout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_data <= '0;
      pin_direction_field <= '0; // Inputs at reset so nothing fights the board
    end
    else if (apb_write && reg_sel == sps_pkg::SPS_SEL_GP_A)
    begin
      gp_data[0] <= pwdata[`SPS_GP_OUT_LSB +: GP_PINS];
      pin_direction_field[0] <= pwdata[`SPS_GP_DIR_LSB +: GP_PINS]; // [RULE13]
    end
    else if (apb_write && reg_sel == sps_pkg::SPS_SEL_GP_B)
    begin
      gp_data[1] <= pwdata[`SPS_GP_OUT_LSB +: GP_PINS];
      pin_direction_field[1] <= pwdata[`SPS_GP_DIR_LSB +: GP_PINS]; // [RULE13]
    end
  end

  // Pin three of A sits on the I/O strobe pin, of B on the I/O select pin
  assign pin_level[0][`SPS_GP_MUXED_PIN] = io_strobe_n_in;
  assign pin_level[1][`SPS_GP_MUXED_PIN] = io_space_select_n_in; // [RULE7]

  // Plain pins: every pin other than three is served identically
  for (genvar s = 0; s < 2; s++)
  begin : g_sub
    for (genvar p = 0; p < GP_PINS; p++)
    begin : g_pin
      if (p != `SPS_GP_MUXED_PIN)
      begin : g_plain
        localparam int D = (p < `SPS_GP_MUXED_PIN) ? p : p - 1;
        assign pin_level[s][p] = gp_pin_in[s][D];
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
          begin
            gp_pin_out[s][D] <= 1'b0;
            gp_pin_oe_n[s][D] <= 1'b1;
          end
          else
          begin
            gp_pin_out[s][D] <= gp_data[s][p]; // [RULE11]
            gp_pin_oe_n[s][D] <= !pin_direction_field[s][p]; // [RULE13]
          end
        end
      end
    end

    // Pin three in host mode: timer, register-driven, or released
    always_comb
    begin
      next_gp3_out[s] = gp_data[s][`SPS_GP_MUXED_PIN];
      next_gp3_oe_n[s] = !pin_direction_field[s][`SPS_GP_MUXED_PIN]; // [RULE9]
      if (host_port_mux_mode)
      begin
        next_gp3_oe_n[s] = 1'b1;
      end
      else if (timer_output_select[s])
      begin
        next_gp3_out[s] = timer_level[s]; // [RULE10]
        next_gp3_oe_n[s] = 1'b0;
      end
    end

    // Branch flag only sees pin two while it is an input
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        branch_condition_input[s] <= 1'b0;
      else
        branch_condition_input[s] <= !pin_direction_field[s][`SPS_GP_BRANCH_PIN] &&
          pin_level[s][`SPS_GP_BRANCH_PIN]; // [RULE12]
    end
  end

  // Space of the access; the enum makes these mutually exclusive
  assign space_prog = cpu_access.valid && cpu_access.space == sps_pkg::SPS_SPACE_PROG;
  assign space_data = cpu_access.valid && cpu_access.space == sps_pkg::SPS_SPACE_DATA;
  assign space_io = cpu_access.valid && cpu_access.space == sps_pkg::SPS_SPACE_IO;

  // Memory-control pins; one cycle behind the request since outputs are flopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_space_select_n_out <= 1'b1;
      data_space_select_n_out <= 1'b1;
      io_space_select_n_out <= 1'b1;
      io_strobe_n_out <= 1'b1;
      program_space_select_n_oe_n <= 1'b1;
      data_space_select_n_oe_n <= 1'b1;
      io_space_select_n_oe_n <= 1'b1;
      io_strobe_n_oe_n <= 1'b1;
    end
    else if (ext_if_sel)
    begin
      program_space_select_n_out <= !space_prog; // [RULE1] [RULE14]
      data_space_select_n_out <= !space_data; // [RULE2] [RULE14]
      io_space_select_n_out <= !space_io; // [RULE3] [RULE8] [RULE14]
      io_strobe_n_out <= !space_io; // [RULE8]
      program_space_select_n_oe_n <= !off_n; // [RULE4]
      data_space_select_n_oe_n <= !off_n; // [RULE4]
      io_space_select_n_oe_n <= !off_n; // [RULE4]
      io_strobe_n_oe_n <= 1'b0;
    end
    else
    begin
      program_space_select_n_out <= 1'b1;
      data_space_select_n_out <= 1'b1;
      io_space_select_n_out <= next_gp3_out[1]; // [RULE7]
      io_strobe_n_out <= next_gp3_out[0];
      program_space_select_n_oe_n <= 1'b1; // [RULE5]
      data_space_select_n_oe_n <= 1'b1; // [RULE6]
      io_space_select_n_oe_n <= next_gp3_oe_n[1] || !off_n; // [RULE4] [RULE7]
      io_strobe_n_oe_n <= next_gp3_oe_n[0];
    end
  end

  // Host strobes are passed in only while the pins are released to the host
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_data_strobe_first <= 1'b1;
      host_data_strobe_second <= 1'b1;
    end
    else
    begin
      host_data_strobe_first <= ext_if_sel || program_space_select_n_in; // [RULE5]
      host_data_strobe_second <= ext_if_sel || data_space_select_n_in; // [RULE6]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ext_access(logic hit);
    ext_if_sel && hit;
  endsequence

  sequence s_host_gp3_b;
    !ext_if_sel && !host_port_mux_mode;
  endsequence

  a_prog_select_on: assert property (s_ext_access(space_prog) |=> // [RULE1]
    !program_space_select_n_out && data_space_select_n_out && io_space_select_n_out)
    else $error("program select not asserted alone");
  a_data_select_on: assert property (s_ext_access(space_data) |=> // [RULE2]
    !data_space_select_n_out && program_space_select_n_out)
    else $error("data select not asserted");
  a_io_select_on: assert property (s_ext_access(space_io) |=> // [RULE3]
    !io_space_select_n_out && !io_strobe_n_out)
    else $error("io select not asserted");
  a_selects_float: assert property (!off_n |=> // [RULE4]
    program_space_select_n_oe_n && data_space_select_n_oe_n && io_space_select_n_oe_n)
    else $error("select pins driven while disabled");
  a_host_strobe_one: assert property (!ext_if_sel |=> // [RULE5]
    program_space_select_n_oe_n && host_data_strobe_first == $past(program_space_select_n_in))
    else $error("first host strobe wrong");
  a_host_strobe_two: assert property (!ext_if_sel |=> // [RULE6]
    data_space_select_n_oe_n && host_data_strobe_second == $past(data_space_select_n_in))
    else $error("second host strobe wrong");
  a_timer_on_b: assert property (s_host_gp3_b ##0 timer_output_select[1] && off_n |=> // [RULE7]
    !io_space_select_n_oe_n && io_space_select_n_out == $past(timer_level[1]))
    else $error("timer not on pin three of B");
  a_io_quiet_else: assert property (s_ext_access(!space_io) |=> // [RULE8]
    io_strobe_n_out && io_space_select_n_out)
    else $error("io strobe active outside io access");
  a_gp3_register_a: assert property (s_host_gp3_b ##0 !timer_output_select[0] |=> // [RULE9]
    io_strobe_n_oe_n == !$past(pin_direction_field[0][3]) &&
    io_strobe_n_out == $past(gp_data[0][3]))
    else $error("pin three of A ignores its register");
  a_pin_two_drive: assert property (pin_direction_field[0][2] |=> // [RULE11]
    !gp_pin_oe_n[0][2] && gp_pin_out[0][2] == $past(gp_data[0][2]))
    else $error("pin two not driven like pins zero and one");
  a_branch_follows: assert property (!pin_direction_field[1][2] |=> // [RULE12]
    branch_condition_input[1] == $past(gp_pin_in[1][2]))
    else $error("branch flag does not follow pin two");
  a_dir_field: assert property ($changed(pin_direction_field[1][0]) |=> // [RULE13]
    gp_pin_oe_n[1][0] == !$past(pin_direction_field[1][0]))
    else $error("pin zero direction not from its field");
  a_select_onehot: assert property ($onehot0( // [RULE14]
    ~{io_space_select_n_out, data_space_select_n_out, program_space_select_n_out}) || !ext_if_sel)
    else $error("more than one space select asserted");
  a_apb_one_wait: assert property (apb_access |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

endmodule // sps_pin_mux

// [shared/sps_consts.svh]
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// Register byte offsets on the APB
`define SPS_REG_CTRL 12'h000
`define SPS_REG_GP_A 12'h004
`define SPS_REG_GP_B 12'h008
`define SPS_REG_STATUS 12'h00C

// Control register fields
`define SPS_CTRL_EXT_IF_BIT 0
`define SPS_CTRL_HOST_MUX_BIT 1
`define SPS_CTRL_TIMER_SEL_LSB 2

// General-purpose register fields (one byte lane each)
`define SPS_GP_OUT_LSB 0
`define SPS_GP_DIR_LSB 8
`define SPS_GP_IN_LSB 16

// Status register fields
`define SPS_STAT_BRANCH_LSB 0
`define SPS_STAT_SEL_LSB 4

// Reset values
`define SPS_EXT_IF_RESET 1'h1
`define SPS_HOST_MUX_RESET 1'h0
`define SPS_TIMER_SEL_RESET 2'h0

// Index of the general-purpose pin that shares a memory-control pin
`define SPS_GP_MUXED_PIN 3
// Index of the general-purpose pin that feeds the branch condition
`define SPS_GP_BRANCH_PIN 2

`endif

// [shared/sps_pkg.sv]
package sps_pkg;

  // Address space of the external access in progress
  typedef enum logic [1:0] {
    SPS_SPACE_NONE,
    SPS_SPACE_PROG,
    SPS_SPACE_DATA,
    SPS_SPACE_IO
  } sps_space_e;

  // Access request from the CPU side
  typedef struct packed {
    logic valid;
    sps_space_e space;
  } sps_access_s;

  // Decoded register selection
  typedef enum logic [2:0] {
    SPS_SEL_CTRL,
    SPS_SEL_GP_A,
    SPS_SEL_GP_B,
    SPS_SEL_STATUS,
    SPS_SEL_NONE
  } sps_reg_e;

endpackage

// [testbench/sps_far_side.sv]
`timescale 1ns/1ps
// Far side of the pins: memory, I/O devices and a host that may drive the strobes
module sps_far_side (
  input wire logic pclk,
  input wire logic host_drive,
  input wire logic [1:0] host_strobe,
  input wire logic ext_drive,
  input wire logic [1:0][3:0] ext_val,
  input wire logic [3:0] sel_out,
  input wire logic [3:0] sel_oe_n,
  input wire logic [1:0][2:0] gp_out,
  input wire logic [1:0][2:0] gp_oe_n,
  output logic [3:0] sel_in,
  output logic [1:0][2:0] gp_in
);
  logic drift = 1'h0;

  // Unpulled lines keep moving so that a stale level never passes for a drive
  always @(posedge pclk)
    drift <= ~drift;

  // Wire levels: device drive first, then the far side, then pull-up or drift
  always_comb
  begin
    sel_in[0] = !sel_oe_n[0] ? sel_out[0] : host_drive ? host_strobe[0] : 1'h1;
    sel_in[1] = !sel_oe_n[1] ? sel_out[1] : host_drive ? host_strobe[1] : 1'h1;
    sel_in[2] = !sel_oe_n[2] ? sel_out[2] : ext_drive ? ext_val[1][3] : drift;
    sel_in[3] = !sel_oe_n[3] ? sel_out[3] : ext_drive ? ext_val[0][3] : drift;
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 3; p++)
        gp_in[s][p] = !gp_oe_n[s][p] ? gp_out[s][p] : ext_drive ? ext_val[s][p] : drift;
  end
endmodule // sps_far_side

// [testbench/tb_space_select_pin_mux.sv]
`timescale 1ns/1ps
`include "sps_consts.svh"
module tb_space_select_pin_mux;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, off_n, host_drive, ext_drive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, hs1, hs2;
  sps_pkg::sps_access_s cpu_access;
  logic [1:0] timer_level, host_strobe, branch;
  logic [1:0][3:0] ext_val;
  logic [3:0] sel_out, sel_oe_n, sel_in;
  logic [1:0][2:0] gp_out, gp_oe_n, gp_in;
  int bad_count = 0;
  int cmp_count = 0;

  // Half period of 25 ns gives the 20 MHz clock
  always #25 pclk = ~pclk;

  sps_pin_mux #(.GP_PINS(4)) i_sps_pin_mux (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_access(cpu_access), .off_n(off_n), .timer_level(timer_level),
    .program_space_select_n_out(sel_out[0]), .program_space_select_n_oe_n(sel_oe_n[0]),
    .program_space_select_n_in(sel_in[0]),
    .data_space_select_n_out(sel_out[1]), .data_space_select_n_oe_n(sel_oe_n[1]),
    .data_space_select_n_in(sel_in[1]),
    .io_space_select_n_out(sel_out[2]), .io_space_select_n_oe_n(sel_oe_n[2]),
    .io_space_select_n_in(sel_in[2]),
    .io_strobe_n_out(sel_out[3]), .io_strobe_n_oe_n(sel_oe_n[3]),
    .io_strobe_n_in(sel_in[3]),
    .host_data_strobe_first(hs1), .host_data_strobe_second(hs2),
    .gp_pin_out(gp_out), .gp_pin_oe_n(gp_oe_n), .gp_pin_in(gp_in),
    .branch_condition_input(branch));

  sps_far_side i_sps_far_side (
    .pclk(pclk), .host_drive(host_drive), .host_strobe(host_strobe),
    .ext_drive(ext_drive), .ext_val(ext_val), .sel_out(sel_out), .sel_oe_n(sel_oe_n),
    .gp_out(gp_out), .gp_oe_n(gp_oe_n), .sel_in(sel_in), .gp_in(gp_in));

  // One APB transfer; the request stands until pready is seen high
  // Only the watchdog ends a wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // An idle edge keeps the next call from driving psel twice in one step
    @(posedge pclk);
  endtask

  // Pins follow their cause one edge later; three edges leave margin
  task automatic tick();
    repeat (3) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the tests need about 120 cycles
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end

  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_access = '{1'h0, sps_pkg::SPS_SPACE_NONE};
    off_n = 1'h1;
    timer_level = 2'h0;
    host_drive = 1'h0;
    host_strobe = 2'h3;
    ext_drive = 1'h0;
    ext_val = 8'h00;
    repeat (2) @(posedge pclk);
    chk({gp_oe_n, hs2, hs1, branch}, 10'h3FC);
    presetn <= 1'h1;
    tick();
    apb(1'h0, `SPS_REG_CTRL, 32'h0);
    chk(rd[3:0], 4'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // Each space in turn must raise exactly its own select
    for (int k = 1; k < 4; k++)
    begin
      cpu_access <= '{1'h1, sps_pkg::sps_space_e'(k)};
      tick();
      chk({sel_out, sel_oe_n}, {k != 3, k != 3, k != 2, k != 1, 4'h0});
      apb(1'h0, `SPS_REG_STATUS, 32'h0);
      chk(rd & 32'h70, 32'h8 << k);
    end
    cpu_access <= '{1'h0, sps_pkg::SPS_SPACE_NONE};
    tick();
    chk(sel_out, 4'hF);
    // Output disable floats the selects even mid-access
    cpu_access <= '{1'h1, sps_pkg::SPS_SPACE_PROG};
    off_n <= 1'h0;
    tick();
    chk(sel_oe_n[2:0], 3'h7);
    off_n <= 1'h1;
    tick();
    chk(sel_oe_n[2:0], 3'h0);
    // Host mode: program and data pins become strobe inputs
    apb(1'h1, `SPS_REG_CTRL, 32'h0);
    host_drive <= 1'h1;
    host_strobe <= 2'h2;
    tick();
    chk({sel_oe_n[1:0], hs2, hs1}, 4'hE);
    host_strobe <= 2'h1;
    tick();
    chk({sel_oe_n[1:0], hs2, hs1}, 4'hD);
    host_drive <= 1'h0;
    cpu_access <= '{1'h0, sps_pkg::SPS_SPACE_NONE};
    // Pin three of each subsystem as general output, then as timer
    apb(1'h1, `SPS_REG_GP_A, 32'h808);
    apb(1'h1, `SPS_REG_GP_B, 32'h800);
    tick();
    chk({sel_out[3:2], sel_oe_n[3:2]}, 4'h8);
    apb(1'h1, `SPS_REG_CTRL, 32'hC);
    timer_level <= 2'h2;
    tick();
    chk(sel_out[3:2], 2'h1);
    timer_level <= 2'h1;
    tick();
    chk(sel_out[3:2], 2'h2);
    timer_level <= 2'h2;
    apb(1'h1, `SPS_REG_CTRL, 32'h0);
    tick();
    chk(sel_out[3:2], 2'h2);
    // Multiplexed host setting releases pin three of both subsystems
    apb(1'h1, `SPS_REG_CTRL, 32'h2);
    tick();
    chk(sel_oe_n[3:2], 2'h3);
    // Pins zero to two, and pin two feeding the branch flag
    apb(1'h1, `SPS_REG_GP_A, 32'h0507);
    apb(1'h1, `SPS_REG_GP_B, 32'h0);
    ext_drive <= 1'h1;
    ext_val <= 8'h40;
    tick();
    chk({gp_oe_n[0], gp_out[0][2], gp_out[0][0], branch}, 7'h2E);
    apb(1'h0, `SPS_REG_GP_B, 32'h0);
    chk(rd[19:16], 4'h4);
    ext_val <= 8'hB0;
    tick();
    chk(branch, 2'h0);
    apb(1'h0, `SPS_REG_GP_B, 32'h0);
    chk(rd[19:16], 4'hB);
    // Subsystem B pins zero and one as outputs, pin two left an input
    apb(1'h1, `SPS_REG_GP_B, 32'h0302);
    tick();
    chk({gp_oe_n[1], gp_out[1]}, 6'h22);
    summarize();
  end
endmodule // tb_space_select_pin_mux
